// >>> verilog/sfdt_pkg.sv
// constants shared by the date-and-time and settings command block
package sfdt_pkg;
   // ===================================
   // opcodes and subcommand codes
   localparam logic [7:0] OP_SET_DATE = 8'h77;
   localparam logic [7:0] OP_SET_FEAT = 8'hef;
   localparam logic [7:0] SF_WC_ON = 8'h02;
   localparam logic [7:0] SF_XFER = 8'h03;
   localparam logic [7:0] SF_APM_ON = 8'h05;
   localparam logic [7:0] SF_PUIS_ON = 8'h06;
   localparam logic [7:0] SF_SPINUP = 8'h07;
   localparam logic [7:0] SF_SATA_ON = 8'h10;
   localparam logic [7:0] SF_HOST_TIME = 8'h43;
   localparam logic [7:0] SF_EPC = 8'h4a;
   localparam logic [7:0] SF_RLA_OFF = 8'h55;
   localparam logic [7:0] SF_REVERT_OFF = 8'h66;
   localparam logic [7:0] SF_WC_OFF = 8'h82;
   localparam logic [7:0] SF_APM_OFF = 8'h85;
   localparam logic [7:0] SF_PUIS_OFF = 8'h86;
   localparam logic [7:0] SF_SATA_OFF = 8'h90;
   localparam logic [7:0] SF_RLA_ON = 8'haa;
   localparam logic [7:0] SF_SENSE = 8'hc3;
   localparam logic [7:0] SF_REVERT_ON = 8'hcc;
   localparam logic [7:0] SF_RDP_CERT = 8'he0;
   // ===================================
   // transfer mode field
   localparam logic [4:0] XT_PIO_DEF = 5'h00;
   localparam logic [4:0] XT_PIO_FC = 5'h01;
   localparam logic [4:0] XT_MDMA = 5'h04;
   localparam logic [4:0] XT_UDMA = 5'h08;
   localparam logic [2:0] XM_IORDY_OFF = 3'h1;
   localparam logic [2:0] XM_PIO_FC_MAX = 3'h4;
   localparam logic [2:0] XM_MDMA_MAX = 3'h2;
   localparam logic [2:0] XM_UDMA_MAX = 3'h6;
   // ===================================
   // serial link feature codes, one settings bit each
   localparam int SATA_N = 7;
   localparam logic [7:0] SATA_CODE [SATA_N] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h09, 8'h0b};
   // ===================================
   // power management levels and idle delays in seconds
   localparam logic [7:0] APM_BAD_LO = 8'h00;
   localparam logic [7:0] APM_BAD_HI = 8'hff;
   localparam logic [7:0] APM_LPI_BASE = 8'h80;
   localparam logic [7:0] APM_IDLE_BASE = 8'hc0;
   localparam logic [7:0] APM_LRPM_BASE = 8'h40;
   localparam logic [8:0] Y1_BASE_SEC = 9'h078;
   localparam logic [8:0] Y1_STEP_SEC = 9'h005;
   localparam logic [12:0] Y2_BASE_SEC = 13'h0258;
   localparam logic [12:0] Y2_STEP_SEC = 13'h003c;
   typedef enum logic [1:0] {
      SFDT_DEEP_IDLE = 2'b00,
      SFDT_DEEP_LPI = 2'b01,
      SFDT_DEEP_LRPM = 2'b10
   } sfdt_deep_t;
   // ===================================
   // error register and register map
   localparam int ERR_ABORT_BIT = 2;
   localparam logic [5:0] RA_SETTINGS = 6'h00;
   localparam logic [5:0] RA_XFER = 6'h04;
   localparam logic [5:0] RA_APM = 6'h08;
   localparam logic [5:0] RA_TS_LO = 6'h0c;
   localparam logic [5:0] RA_TS_HI = 6'h10;
   localparam logic [5:0] RA_HOST_TIME = 6'h14;
   localparam logic [5:0] RA_CTRL = 6'h18;
   localparam logic [5:0] RA_ERROR = 6'h1c;
   localparam int CTRL_REASSIGN_FULL = 0;
endpackage : sfdt_pkg

// >>> verilog/sfdt_apm_if.sv
// carrier between the command decoder and the idle delay calculator
`timescale 1ns/1ps
`default_nettype none
interface sfdt_apm_if;
   import sfdt_pkg::*;
   logic [7:0] level;
   logic y1_set;
   logic [8:0] y1_now;
   sfdt_deep_t deep;
   logic [8:0] y1_new;
   logic [12:0] y2_new;
   modport calc (input level, input y1_set, input y1_now,
                 output deep, output y1_new, output y2_new);
   modport user (output level, output y1_set, output y1_now,
                 input deep, input y1_new, input y2_new);
endinterface : sfdt_apm_if
`default_nettype wire

// >>> verilog/sfdt_apm_calc.sv
// idle delay calculator for an advanced power management level
`timescale 1ns/1ps
`default_nettype none
module sfdt_apm_calc
   import sfdt_pkg::*;
(
   // level in, delays out
   sfdt_apm_if.calc apm
);
   // ===================================
   // level classes
   wire is_idle = apm.level >= APM_IDLE_BASE;
   wire is_lpi = apm.level >= APM_LPI_BASE && !is_idle;
   wire is_lrpm_hi = apm.level >= APM_LRPM_BASE && apm.level < APM_LPI_BASE;
   wire [5:0] step = apm.level[5:0];
   wire [8:0] y1_lpi = Y1_BASE_SEC + 9'(step) * Y1_STEP_SEC;
   wire [12:0] y2_hi = Y2_BASE_SEC + 13'(step) * Y2_STEP_SEC;
   wire [8:0] y1_kept = apm.y1_set ? apm.y1_now : Y1_BASE_SEC;

   assign apm.deep = is_idle ? SFDT_DEEP_IDLE : (is_lpi ? SFDT_DEEP_LPI : SFDT_DEEP_LRPM);
   assign apm.y1_new = is_idle ? Y1_BASE_SEC : (is_lpi ? y1_lpi : y1_kept);
   // no low rpm delay in low power idle; fixed floor below the upper band
   assign apm.y2_new = (is_idle || is_lpi) ? 13'h0000
                       : (is_lrpm_hi ? y2_hi : Y2_BASE_SEC);
endmodule : sfdt_apm_calc
`default_nettype wire

// >>> verilog/sfdt_cmd.sv
// set date-and-time and set-features command interpreter
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sfdt_cmd
   import sfdt_pkg::*;
(
   // clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hard_reset,
   input wire logic soft_reset,
   // command from the link layer
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic [7:0] cmd_feature,
   input wire logic [7:0] cmd_count,
   input wire logic [47:0] cmd_lba,
   output logic cmd_done,
   output logic [7:0] cmd_error,
   // settings to the rest of the drive
   output logic write_cache_on,
   output logic look_ahead_on,
   output logic apm_on,
   output logic [1:0] apm_deepest,
   output logic [8:0] lpi_delay_sec,
   output logic [12:0] lrpm_delay_sec,
   output logic standby_powerup_on,
   output logic spinup_req,
   output logic [47:0] timestamp,
   output logic pio_full_rate,
   output logic dma_full_rate,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // ===================================
   // reset release
   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ===================================
   // command decode
   logic revert_on;
   logic y1_set;
   logic reassign_full;
   wire any_reset = hard_reset || soft_reset;
   wire take = cmd_valid && !any_reset;
   wire is_date = take && cmd_opcode == OP_SET_DATE;
   wire is_feat = take && cmd_opcode == OP_SET_FEAT;
   wire [7:0] f = cmd_feature;
   wire f_xfer = f == SF_XFER;
   wire f_apm = f == SF_APM_ON;
   wire f_sata = f == SF_SATA_ON || f == SF_SATA_OFF;
   wire f_sense = f == SF_SENSE;
   wire known = f == SF_WC_ON || f_xfer || f_apm || f == SF_PUIS_ON || f == SF_SPINUP
                || f_sata || f == SF_HOST_TIME || f == SF_EPC || f == SF_RLA_OFF
                || f == SF_REVERT_OFF || f == SF_WC_OFF || f == SF_APM_OFF
                || f == SF_PUIS_OFF || f == SF_RLA_ON || f_sense || f == SF_REVERT_ON
                || f == SF_RDP_CERT;

   wire [4:0] xt = cmd_count[7:3];
   wire [2:0] xm = cmd_count[2:0];
   wire xfer_ok = (xt == XT_PIO_DEF && xm <= XM_IORDY_OFF)
                  || (xt == XT_PIO_FC && xm <= XM_PIO_FC_MAX)
                  || (xt == XT_MDMA && xm <= XM_MDMA_MAX)
                  || (xt == XT_UDMA && xm <= XM_UDMA_MAX);

   logic [SATA_N-1:0] sata_hit;
   wire sata_ok = |sata_hit;
   wire apm_ok = cmd_count != APM_BAD_LO && cmd_count != APM_BAD_HI;

   wire abort = is_feat && (!known || (f_xfer && !xfer_ok) || (f_sata && !sata_ok)
                || (f_apm && !apm_ok) || (f_sense && !cmd_count[0]));
   wire go = is_feat && !abort;
   wire do_wc_on = go && f == SF_WC_ON;
   wire do_wc_off = go && f == SF_WC_OFF;
   wire do_rla_on = go && f == SF_RLA_ON;
   wire do_rla_off = go && f == SF_RLA_OFF;
   wire do_rev_on = go && f == SF_REVERT_ON;
   wire do_rev_off = go && f == SF_REVERT_OFF;
   wire do_puis_on = go && f == SF_PUIS_ON;
   wire do_puis_off = go && f == SF_PUIS_OFF;
   wire do_xfer = go && f_xfer;
   wire do_host = go && f == SF_HOST_TIME;
   wire do_apm = go && f_apm;
   wire do_apm_off = go && f == SF_APM_OFF;
   // power state is wiped by hard reset, or by soft reset only when reverting
   wire apm_init = hard_reset || (soft_reset && revert_on);

   // ===================================
   // idle delay calculator
   sfdt_apm_if apm_bus ();
   assign apm_bus.level = cmd_count;
   assign apm_bus.y1_set = y1_set;
   assign apm_bus.y1_now = lpi_delay_sec;
   sfdt_apm_calc u_calc (
      .apm (apm_bus.calc)
   );
   wire to_idle = do_apm_off || (do_apm && apm_bus.deep == SFDT_DEEP_IDLE);

   // ===================================
   // command completion
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_done <= 1'b0;
         cmd_error <= 8'h00;
      end else begin
         cmd_done <= is_date || is_feat;
         if (is_date || is_feat) begin
            cmd_error <= 8'h00;
            cmd_error[ERR_ABORT_BIT] <= abort;
         end
      end
   end
   wire command_abort_flag = cmd_error[ERR_ABORT_BIT];

   // ===================================
   // timestamp and host sector times
   logic [15:0] pio_time;
   logic [15:0] dma_time;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timestamp <= 48'h0;
         pio_time <= 16'h0000;
         dma_time <= 16'h0000;
      end else begin
         if (is_date) timestamp <= cmd_lba;
         if (do_host) begin
            pio_time <= {cmd_lba[7:0], cmd_count};
            dma_time <= cmd_lba[23:8];
         end
      end
   end
   assign pio_full_rate = pio_time == 16'h0000;
   assign dma_full_rate = dma_time == 16'h0000;

   // ===================================
   // feature switches
   logic wc_req;
   logic rla;
   logic [7:0] xfer_mode;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wc_req <= 1'b1;
         rla <= 1'b1;
         revert_on <= 1'b0;
         standby_powerup_on <= 1'b0;
         spinup_req <= 1'b0;
         xfer_mode <= 8'h00;
      end else if (hard_reset) begin
         wc_req <= 1'b1;
         rla <= 1'b1;
         revert_on <= 1'b0;
         spinup_req <= 1'b0;
      end else begin
         if (do_wc_on) wc_req <= 1'b1;
         if (do_wc_off) wc_req <= 1'b0;
         if (do_rla_on) rla <= 1'b1;
         if (do_rla_off) rla <= 1'b0;
         if (do_rev_on) revert_on <= 1'b1;
         if (do_rev_off) revert_on <= 1'b0;
         if (do_puis_on) standby_powerup_on <= 1'b1;
         if (do_puis_off) standby_powerup_on <= 1'b0;
         spinup_req <= go && f == SF_SPINUP;
         if (do_xfer) xfer_mode <= cmd_count;
      end
   end
   // the request is kept so the cache comes back by itself once reassign_full clears
   assign write_cache_on = wc_req && !reassign_full;
   assign look_ahead_on = rla;

   // ===================================
   // serial link feature bits
   logic [SATA_N-1:0] sata_en;
   genvar gi;
   generate
      for (gi = 0; gi < SATA_N; gi++) begin : g_sata
         assign sata_hit[gi] = cmd_count == SATA_CODE[gi];
         always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               sata_en[gi] <= 1'b0;
            end else if (go && f_sata && sata_hit[gi]) begin
               sata_en[gi] <= f == SF_SATA_ON;
            end
         end
      end
   endgenerate

   // ===================================
   // power management state
   logic [7:0] apm_level;
   sfdt_deep_t deep;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         apm_on <= 1'b0;
         deep <= SFDT_DEEP_IDLE;
         apm_level <= 8'h00;
         y1_set <= 1'b0;
         lpi_delay_sec <= Y1_BASE_SEC;
         lrpm_delay_sec <= 13'h0000;
      end else if (apm_init || to_idle) begin
         apm_on <= do_apm;
         deep <= SFDT_DEEP_IDLE;
         apm_level <= do_apm ? cmd_count : 8'h00;
         y1_set <= 1'b0;
         lpi_delay_sec <= Y1_BASE_SEC;
         lrpm_delay_sec <= 13'h0000;
      end else if (do_apm) begin
         apm_on <= 1'b1;
         deep <= apm_bus.deep;
         apm_level <= cmd_count;
         y1_set <= 1'b1;
         lpi_delay_sec <= apm_bus.y1_new;
         lrpm_delay_sec <= apm_bus.y2_new;
      end
   end
   assign apm_deepest = deep;

   // ===================================
   // register port
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reassign_full <= 1'b0;
      end else if (reg_wr && reg_addr == RA_CTRL) begin
         reassign_full <= reg_wdata[CTRL_REASSIGN_FULL];
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      unique case (reg_addr)
         RA_SETTINGS: rd_mux = {16'h0, 1'b0, sata_en, 2'(deep), apm_on,
                                standby_powerup_on, 1'b0, revert_on, rla, write_cache_on};
         RA_XFER: rd_mux = {24'h0, xfer_mode};
         RA_APM: rd_mux = {apm_level, lpi_delay_sec[7:0], 1'b0, lpi_delay_sec[8],
                           1'b0, lrpm_delay_sec};
         RA_TS_LO: rd_mux = timestamp[31:0];
         RA_TS_HI: rd_mux = {16'h0, timestamp[47:32]};
         RA_HOST_TIME: rd_mux = {dma_time, pio_time};
         RA_CTRL: rd_mux = {31'h0, reassign_full};
         RA_ERROR: rd_mux = {24'h0, cmd_error};
         default: rd_mux = 32'h0;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) reg_rdata <= 32'h0;
      else if (reg_rd) reg_rdata <= rd_mux;
      else reg_rdata <= 32'h0;
   end

   // ===================================
   // checks
   chk_date_load: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      is_date |=> timestamp == $past(cmd_lba) && cmd_done && !command_abort_flag)
      else $error("timestamp not loaded");
   chk_abort_unknown: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      is_feat && !known |=> cmd_done && command_abort_flag)
      else $error("unknown subcommand not aborted");
   chk_revert_codes: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      go && f == SF_REVERT_OFF && !hard_reset |=> !revert_on)
      else $error("revert not disabled");
   chk_rla_codes: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      go && f == SF_RLA_ON |=> look_ahead_on)
      else $error("look-ahead not enabled");
   chk_hard_defaults: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      hard_reset |=> look_ahead_on && !revert_on && (write_cache_on || reassign_full))
      else $error("hard reset defaults wrong");
   chk_cache_forced: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      reassign_full |-> !write_cache_on)
      else $error("cache on while capacity full");
   chk_cache_accept: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_wc_on |=> cmd_done && !command_abort_flag && write_cache_on == !reassign_full)
      else $error("enable-cache not accepted cleanly");
   chk_apm_bad_level: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      is_feat && f_apm && (cmd_count == 8'hff || cmd_count == 8'h00)
      |=> command_abort_flag && $stable(apm_on))
      else $error("bad power level accepted");
   chk_soft_keep: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      soft_reset && !hard_reset && !revert_on |=> $stable(lpi_delay_sec) && $stable(apm_on))
      else $error("soft reset changed power state");
   chk_host_time: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_host |=> pio_time == {$past(cmd_lba[7:0]), $past(cmd_count)}
                  && dma_full_rate == ($past(cmd_lba[23:8]) == 16'h0000))
      else $error("host sector times wrong");
   chk_xfer_bad: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      is_feat && f_xfer && cmd_count == 8'h47
      |=> cmd_done && command_abort_flag && xfer_mode == $past(xfer_mode))
      else $error("illegal ultra mode accepted");
   chk_apm_off: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_apm_off |=> !apm_on && apm_deepest == SFDT_DEEP_IDLE && lrpm_delay_sec == 13'h0000)
      else $error("power management not disabled");
   chk_spinup_pulse: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      go && f == SF_SPINUP |=> spinup_req)
      else $error("spin-up not requested");
   chk_sata_bit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      go && f == SF_SATA_ON && sata_hit[SATA_N-1] |=> sata_en[SATA_N-1])
      else $error("serial link feature not enabled");
   // expected delays are worked from the level, not taken from the calculator
   chk_lpi_delay: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_apm && cmd_count[7:6] == 2'b10
      |=> lpi_delay_sec == Y1_BASE_SEC + 9'($past(cmd_count) - APM_LPI_BASE) * Y1_STEP_SEC
          && apm_deepest == SFDT_DEEP_LPI && lrpm_delay_sec == 13'h0000)
      else $error("low power idle delay wrong");
   chk_lrpm_upper: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_apm && cmd_count[7:6] == 2'b01
      |=> lrpm_delay_sec == Y2_BASE_SEC + 13'($past(cmd_count) - APM_LRPM_BASE) * Y2_STEP_SEC)
      else $error("low rpm idle delay wrong");
   chk_lrpm_floor: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_apm && cmd_count[7:6] == 2'b00
      |=> lrpm_delay_sec == Y2_BASE_SEC && apm_deepest == SFDT_DEEP_LRPM)
      else $error("low rpm floor delay wrong");
   chk_lpi_kept: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      do_apm && !cmd_count[7]
      |=> lpi_delay_sec == ($past(y1_set) ? $past(lpi_delay_sec) : Y1_BASE_SEC))
      else $error("low power idle delay not kept");
   chk_hard_apm: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
      hard_reset |=> !apm_on && lpi_delay_sec == Y1_BASE_SEC && lrpm_delay_sec == 13'h0000)
      else $error("hard reset kept power state");
endmodule : sfdt_cmd
`default_nettype wire

// >>> tb/sfdt_host_model.sv
// host controller model that presents commands to the block
`timescale 1ns/1ps
`default_nettype none
module sfdt_host_model
   import sfdt_pkg::*;
(
   // clock
   input wire logic clk,
   // command out
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [7:0] cmd_feature,
   output logic [7:0] cmd_count,
   output logic [47:0] cmd_lba,
   // answer in
   input wire logic cmd_done,
   input wire logic [7:0] cmd_error
);
   logic done_seen = 1'b0;
   logic abort_seen = 1'b0;
   initial begin
      cmd_valid = 1'b0;
      cmd_opcode = 8'h00;
      cmd_feature = 8'h00;
      cmd_count = 8'h00;
      cmd_lba = 48'h0;
   end
   // timestamps handed in are host time in ms since the start of 1970
   task automatic issue(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] ct,
                        input logic [47:0] lb);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_feature <= ft;
      cmd_count <= ct;
      cmd_lba <= lb;
      @(posedge clk);
      cmd_valid <= 1'b0;
      // released fields carry the inverse so nothing can lean on stale values
      cmd_opcode <= ~op;
      cmd_feature <= ~ft;
      cmd_count <= ~ct;
      cmd_lba <= ~lb;
      #1;
      done_seen = cmd_done;
      abort_seen = cmd_error[ERR_ABORT_BIT];
   endtask : issue
endmodule : sfdt_host_model
`default_nettype wire

// >>> tb/sfdt_cmd_tb.sv
// self-checking bench for the date-and-time and settings command block
`timescale 1ns/1ps
`default_nettype none
module sfdt_cmd_tb;
   import sfdt_pkg::*;
   // ===================================
   // signals
   localparam logic [7:0] XM [9] = '{8'h00, 8'h01, 8'h0c, 8'h0d, 8'h22, 8'h23, 8'h46, 8'h47,
                                     8'h10};
   localparam logic XA [9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hard_reset = 1'b0;
   logic soft_reset = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cmd_valid, cmd_done, write_cache_on, look_ahead_on, apm_on, standby_powerup_on;
   logic spinup_req, pio_full_rate, dma_full_rate;
   logic [7:0] cmd_opcode, cmd_feature, cmd_count, cmd_error, xexp;
   logic [47:0] cmd_lba, timestamp;
   logic [1:0] apm_deepest;
   logic [8:0] lpi_delay_sec;
   logic [12:0] lrpm_delay_sec;
   logic [31:0] reg_rdata, rd;
   int failures = 0;
   int total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   sfdt_host_model host (.clk(sys_clk), .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_count,
                         .cmd_lba, .cmd_done, .cmd_error);
   sfdt_cmd dut (.sys_clk, .rst_n, .hard_reset, .soft_reset, .cmd_valid, .cmd_opcode,
                 .cmd_feature, .cmd_count, .cmd_lba, .cmd_done, .cmd_error, .write_cache_on,
                 .look_ahead_on, .apm_on, .apm_deepest, .lpi_delay_sec, .lrpm_delay_sec,
                 .standby_powerup_on, .spinup_req, .timestamp, .pio_full_rate,
                 .dma_full_rate, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   // ===================================
   // tasks
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rdr(input logic [5:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : rdr
   task automatic cmd(input logic [7:0] ft, input logic [7:0] ct, input logic [47:0] lb,
                      input logic ab);
      host.issue(OP_SET_FEAT, ft, ct, lb);
      chk(host.done_seen, 1'b1);
      chk(host.abort_seen, ab);
   endtask : cmd
   task automatic pulse(input logic hard);
      @(posedge sys_clk);
      hard_reset <= hard;
      soft_reset <= !hard;
      @(posedge sys_clk);
      hard_reset <= 1'b0;
      soft_reset <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : pulse
   // ===================================
   // sequence
   initial begin
      #2_000_000;
      failures++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(write_cache_on, 1'b1);
      chk(look_ahead_on, 1'b1);
      rdr(RA_SETTINGS);
      chk(rd[3:2], 2'b00);
      host.issue(OP_SET_DATE, 8'hff, 8'h5a, 48'h8123_4567_89ab);
      chk(host.done_seen, 1'b1);
      chk(timestamp, 48'h8123_4567_89ab);
      rdr(RA_TS_HI);
      chk(rd, 32'h0000_8123);
      host.issue(8'h00, 8'h02, 8'h00, 48'h0);
      chk(host.done_seen, 1'b0);
      cmd(8'h01, 8'h00, 48'h0, 1'b1);
      cmd(SF_RLA_OFF, 8'h00, 48'h0, 1'b0);
      chk(look_ahead_on, 1'b0);
      cmd(SF_RLA_ON, 8'h00, 48'h0, 1'b0);
      chk(look_ahead_on, 1'b1);
      // fresh low rpm level: y1 falls back to its default
      cmd(SF_APM_ON, 8'h40, 48'h0, 1'b0);
      chk({apm_on, apm_deepest, lpi_delay_sec}, {1'b1, SFDT_DEEP_LRPM, 9'h078});
      chk(lrpm_delay_sec, 13'h0258);
      cmd(SF_APM_ON, 8'hbf, 48'h0, 1'b0);
      chk({apm_deepest, lpi_delay_sec}, {SFDT_DEEP_LPI, 9'h1b3});
      cmd(SF_APM_ON, 8'h7f, 48'h0, 1'b0);
      chk({lpi_delay_sec, lrpm_delay_sec}, {9'h1b3, 13'h111c});
      cmd(SF_APM_ON, 8'h3f, 48'h0, 1'b0);
      chk(lrpm_delay_sec, 13'h0258);
      cmd(SF_APM_ON, 8'hff, 48'h0, 1'b1);
      cmd(SF_APM_ON, 8'h00, 48'h0, 1'b1);
      chk({apm_on, apm_deepest, lpi_delay_sec}, {1'b1, SFDT_DEEP_LRPM, 9'h1b3});
      pulse(1'b0);
      chk({apm_on, lpi_delay_sec}, {1'b1, 9'h1b3});
      cmd(SF_REVERT_ON, 8'h00, 48'h0, 1'b0);
      rdr(RA_SETTINGS);
      chk(rd[2], 1'b1);
      pulse(1'b0);
      chk({apm_on, lpi_delay_sec}, {1'b0, 9'h078});
      cmd(SF_APM_ON, 8'h80, 48'h0, 1'b0);
      chk({apm_deepest, lpi_delay_sec}, {SFDT_DEEP_LPI, 9'h078});
      cmd(SF_APM_ON, 8'hc0, 48'h0, 1'b0);
      chk(apm_deepest, SFDT_DEEP_IDLE);
      cmd(SF_APM_OFF, 8'h00, 48'h0, 1'b0);
      chk(apm_on, 1'b0);
      cmd(SF_APM_ON, 8'h90, 48'h0, 1'b0);
      cmd(SF_RLA_OFF, 8'h00, 48'h0, 1'b0);
      pulse(1'b1);
      chk({apm_on, look_ahead_on}, 2'b01);
      rdr(RA_SETTINGS);
      chk(rd[2], 1'b0);
      cmd(SF_REVERT_OFF, 8'h00, 48'h0, 1'b0);
      xexp = 8'h00;
      for (int i = 0; i < 9; i++) begin
         cmd(SF_XFER, XM[i], 48'h0, XA[i]);
         if (!XA[i]) begin
            xexp = XM[i];
         end
         rdr(RA_XFER);
         chk(rd[7:0], xexp);
      end
      // full reassignment forces the cache off yet 02h still completes cleanly
      cmd(SF_WC_OFF, 8'h00, 48'h0, 1'b0);
      chk(write_cache_on, 1'b0);
      wr(RA_CTRL, 32'h0000_0001);
      cmd(SF_WC_ON, 8'h00, 48'h0, 1'b0);
      chk(write_cache_on, 1'b0);
      wr(RA_CTRL, 32'h0000_0000);
      chk(write_cache_on, 1'b1);
      for (int i = 0; i < SATA_N; i++) begin
         cmd(SF_SATA_ON, SATA_CODE[i], 48'h0, 1'b0);
         rdr(RA_SETTINGS);
         chk(rd[8 + i], 1'b1);
         cmd(SF_SATA_OFF, SATA_CODE[i], 48'h0, 1'b0);
         rdr(RA_SETTINGS);
         chk(rd[8 + i], 1'b0);
      end
      cmd(SF_HOST_TIME, 8'h34, 48'h0000_00be_ef12, 1'b0);
      rdr(RA_HOST_TIME);
      chk(rd, 32'hbeef_1234);
      chk({pio_full_rate, dma_full_rate}, 2'b00);
      cmd(SF_HOST_TIME, 8'h00, 48'h0000_0001_0000, 1'b0);
      chk({pio_full_rate, dma_full_rate}, 2'b10);
      cmd(SF_PUIS_ON, 8'h00, 48'h0, 1'b0);
      chk(standby_powerup_on, 1'b1);
      cmd(SF_SPINUP, 8'h00, 48'h0, 1'b0);
      chk(spinup_req, 1'b1);
      cmd(SF_PUIS_OFF, 8'h00, 48'h0, 1'b0);
      chk({standby_powerup_on, spinup_req}, 2'b00);
      rdr(6'h3c);
      chk(rd, 32'h0);
      final_report();
   end
endmodule : sfdt_cmd_tb
`default_nettype wire
